/* File: dv/npxc_host_mem.sv */
// Host-side image memory for the control unit's word transfers.
// Assumes one request at a time; answers each read three cycles late.
`timescale 1ns/1ps
module npxc_host_mem (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        xfer_rd_q,
    input  wire logic        xfer_wr_q,
    input  wire logic [5:0]  xfer_addr_q,
    input  wire logic [15:0] xfer_wdata_q,
    output logic      [15:0] xfer_rdata,
    output logic             xfer_rvalid
);
    logic [15:0] mem [64];
    logic [5:0]  addr_q;
    logic [1:0]  wait_q;
    // Data bus toggles when idle so a stale word is never mistaken for an answer
    always @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            wait_q <= 2'h0;
            xfer_rvalid <= 1'b0;
            xfer_rdata <= 16'h0000;
        end
        else
        begin
            if (xfer_wr_q)
                mem[xfer_addr_q] <= xfer_wdata_q;
            xfer_rvalid <= wait_q == 2'h1;
            xfer_rdata <= wait_q == 2'h1 ? mem[addr_q] : ~xfer_rdata;
            if (xfer_rd_q)
            begin
                addr_q <= xfer_addr_q;
                wait_q <= 2'h2;
            end
            else if (wait_q != 2'h0)
                wait_q <= wait_q - 2'h1;
        end
endmodule // npxc_host_mem

/* File: dv/tb.sv */
// Testbench of the control unit: registers, head moves, stores, reloads.
// Assumes the host memory model answers reads three cycles late.
`timescale 1ns/1ps
module tb import npxc_pkg::*;;
    logic        clk = 0, rstn = 0, op_valid = 0, op_checked = 0, host_sync = 0;
    logic        prot_mode = 0, v86_mode = 0, opsize32 = 0, numeric_busy = 0;
    logic        reg_wr = 0, reg_rd = 0, xfer_rvalid, xfer_rd_q, xfer_wr_q;
    logic        op_busy_q, op_done_q, op_err_q, numeric_fault_line_q;
    logic [3:0]  op_code = 4'h0;
    logic [2:0]  op_reg = 3'h0, reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, xfer_rdata, xfer_wdata_q;
    logic [5:0]  xfer_addr_q;
    int          failures = 0, checked = 0;

    npxc_control_unit i_npxc_control_unit (.clk(clk), .rstn(rstn), .op_valid(op_valid),
        .op_code(op_code), .op_reg(op_reg), .op_checked(op_checked),
        .host_sync(host_sync), .prot_mode(prot_mode), .v86_mode(v86_mode),
        .opsize32(opsize32), .numeric_busy(numeric_busy), .xfer_rdata(xfer_rdata),
        .xfer_rvalid(xfer_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .op_busy_q(op_busy_q), .op_done_q(op_done_q), .op_err_q(op_err_q),
        .xfer_rd_q(xfer_rd_q), .xfer_wr_q(xfer_wr_q), .xfer_addr_q(xfer_addr_q),
        .xfer_wdata_q(xfer_wdata_q), .numeric_fault_line_q(numeric_fault_line_q));
    npxc_host_mem i_npxc_host_mem (.clk(clk), .rstn(rstn), .xfer_rd_q(xfer_rd_q),
        .xfer_wr_q(xfer_wr_q), .xfer_addr_q(xfer_addr_q), .xfer_wdata_q(xfer_wdata_q),
        .xfer_rdata(xfer_rdata), .xfer_rvalid(xfer_rvalid));

    initial forever #5 clk = ~clk;

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e, input string n);
        @(posedge clk) reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk) reg_rd <= 1'b0;
        #1 chk(n, reg_rdata_q, e);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk) reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    // Bounded wait for completion; a hang counts as a mismatch
    task automatic op(input logic [3:0] c, input logic ck);
        @(posedge clk) op_valid <= 1'b1;
        op_code <= c;
        op_checked <= ck;
        @(posedge clk) op_valid <= 1'b0;
        #1 chk("busy", 16'(op_busy_q), 16'h0001);
        for (int i = 0; i < 3000 && op_done_q !== 1'b1; i++)
            @(posedge clk) #1;
        chk("done", 16'(op_done_q), 16'h0001);
    endtask
    task automatic t_head;
        rd(RA_CTRL, CTRL_RST, "ctrl");
        rd(3'h7, 16'h0000, "unmapped");
        op(OP_RET, 1'b0);
        rd(RA_STAT, 16'h3800, "head");
        op(OP_IDLE, 1'b0);
        rd(RA_STAT, 16'h3800, "idle");
        op(OP_ADV, 1'b0);
        rd(RA_STAT, 16'h0000, "head");
        rd(RA_TAG, TAG_RST, "tag");
    endtask
    task automatic t_store;
        i_npxc_host_mem.mem[0] = 16'hDEAD;
        i_npxc_host_mem.mem[7] = 16'hDEAD;
        wr(RA_CTRL, 16'h0340);
        numeric_busy <= 1'b1;
        fork
            op(OP_STENV, 1'b0);
            begin
                repeat (30) @(posedge clk);
                chk("held", i_npxc_host_mem.mem[0], 16'hDEAD);
                numeric_busy <= 1'b0;
            end
        join
        chk("ctrl img", i_npxc_host_mem.mem[0], 16'h0340);
        chk("tag img", i_npxc_host_mem.mem[2], 16'hFFFF);
        chk("img end", i_npxc_host_mem.mem[7], 16'hDEAD);
        rd(RA_CTRL, 16'h037F, "masks");
    endtask
    task automatic t_load;
        for (int k = 0; k < 47; k++)
            i_npxc_host_mem.mem[k] = 16'h0000;
        i_npxc_host_mem.mem[1] = 16'h0001;
        op(OP_LDENV, 1'b0);
        rd(RA_CTRL, 16'h0000, "ctrl");
        chk("quiet", 16'(numeric_fault_line_q), 16'h0000);
        @(posedge clk) host_sync <= 1'b1;
        @(posedge clk) host_sync <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("fault", 16'(numeric_fault_line_q), 16'h0001);
        op(OP_ADV, 1'b1);
        chk("err", 16'(op_err_q), 16'h0001);
        rd(RA_STAT, 16'h0081, "refused");
        op(OP_VACATE, 1'b0);
        rd(RA_TAG, 16'h0003, "vacate");
        wr(RA_CTRL, 16'h003F);
        repeat (3) @(posedge clk);
        #1 chk("fault", 16'(numeric_fault_line_q), 16'h0000);
        wr(RA_CTRL, 16'h0000);
        repeat (3) @(posedge clk);
        #1 chk("fault", 16'(numeric_fault_line_q), 16'h0001);
    endtask
    task automatic t_restore;
        i_npxc_host_mem.mem[0] = 16'h037F;
        i_npxc_host_mem.mem[1] = 16'h1800;
        i_npxc_host_mem.mem[2] = 16'hFFFC;
        op(OP_RESTORE, 1'b0);
        rd(RA_STAT, 16'h1800, "status");
        rd(RA_CTRL, 16'h037F, "ctrl");
    endtask
    task automatic t_wide;
        i_npxc_host_mem.mem[9] = 16'hDEAD;
        wr(RA_IPSEL, 16'h1234);
        wr(RA_IPOFF, 16'h0010);
        prot_mode <= 1'b1;
        opsize32 <= 1'b1;
        op(OP_STENV, 1'b0);
        chk("sel32", i_npxc_host_mem.mem[8], 16'h1234);
        chk("pad32", i_npxc_host_mem.mem[9], 16'h0000);
        chk("tag32", i_npxc_host_mem.mem[4], 16'hFFFD);
        @(posedge clk) prot_mode <= 1'b0;
        opsize32 <= 1'b0;
        op(OP_STENV, 1'b0);
        chk("lin", i_npxc_host_mem.mem[3], 16'h2350);
        chk("seg", i_npxc_host_mem.mem[4], 16'h1000);
        chk("tag16", i_npxc_host_mem.mem[2], 16'hFFFD);
    endtask

    initial
    begin
        #200000;
        failures++;
        conclude;
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_head;
        t_store;
        t_load;
        t_restore;
        t_wide;
        conclude;
    end
endmodule // tb

/* File: src/npxc_control_unit.sv */
// Control-instruction executor of the numeric coprocessor: environment transfers,
// full-state restore, head pointer moves, slot vacate, idle op, fault line.
// Assumes the host issues one opcode at a time and moves image words for us.
`timescale 1ns/1ps
module npxc_control_unit
    import npxc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        op_valid,
    input  wire logic [3:0]  op_code,
    input  wire logic [2:0]  op_reg,
    input  wire logic        op_checked,
    input  wire logic        host_sync,
    input  wire logic        prot_mode,
    input  wire logic        v86_mode,
    input  wire logic        opsize32,
    input  wire logic        numeric_busy,
    input  wire logic [15:0] xfer_rdata,
    input  wire logic        xfer_rvalid,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata_q,
    output logic             op_busy_q,
    output logic             op_done_q,
    output logic             op_err_q,
    output logic             xfer_rd_q,
    output logic             xfer_wr_q,
    output logic      [5:0]  xfer_addr_q,
    output logic      [15:0] xfer_wdata_q,
    output logic             numeric_fault_line_q
);

    npxc_state_type state_q;
    logic [15:0]    ctrl_q;
    logic [15:0]    stat_q;
    logic [15:0]    tag_q;
    logic [15:0]    ipoff_q;
    logic [15:0]    ipsel_q;
    logic [15:0]    opoff_q;
    logic [15:0]    opsel_q;
    logic [15:0]    tscan_q;
    logic [3:0]     opc_q;
    logic           wide_q;
    logic           real_q;
    logic [5:0]     k_q;
    logic [2:0]     ri_q;
    logic [2:0]     wj_q;
    logic           pv_q;
    logic [2:0]     pri_q;
    logic [2:0]     pwj_q;
    logic           mnz_q;
    logic           int_q;
    logic           cw_upd_q;
    logic           pending;
    logic           accept;
    logic           refuse;
    logic           go;
    logic [2:0]     top;
    logic [5:0]     nenv;
    logic [5:0]     ntot;
    logic           k_last;
    logic           scan_last;
    logic [2:0]     env_idx;
    logic           ld_we;
    logic           ld_fld;
    logic           mem_we;
    logic [5:0]     mem_waddr;
    logic [5:0]     mem_raddr;
    logic [15:0]    mem_rdata;
    logic [19:0]    ip_lin;
    logic [19:0]    op_lin;
    logic [15:0]    stat_rd;
    logic [15:0]    env_wd;
    logic [1:0]     cls;
    logic [2:0]     vac_slot;

    assign pending   = |(stat_q[EXC_W-1:0] & ~ctrl_q[EXC_W-1:0]);
    assign accept    = (state_q == S_IDLE) && op_valid;
    assign refuse    = accept && op_checked && pending;
    assign go        = accept && !refuse;
    assign top       = stat_q[ST_TOP_LO +: ST_TOP_W];
    assign nenv      = wide_q ? {ENV_WORDS[4:0], 1'b0} : ENV_WORDS;
    assign ntot      = (opc_q == OP_RESTORE) ? 6'(nenv + DATA_WORDS) : nenv;
    assign k_last    = (k_q == 6'(ntot - 6'h01));
    assign scan_last = (ri_q == SLOT_LAST) && (wj_q == WORD_LAST);
    assign env_idx   = wide_q ? k_q[3:1] : k_q[2:0];
    assign ld_we     = (state_q == S_LWAIT) && xfer_rvalid;
    // High halves of the 32-bit image carry nothing we keep
    assign ld_fld    = ld_we && (k_q < nenv) && !(wide_q && k_q[0]);
    assign mem_we    = ld_we && (k_q >= nenv);
    assign mem_waddr = 6'(k_q - nenv);
    assign mem_raddr = 6'(6'(ri_q) * SLOT_WORDS + 6'(wj_q));
    assign ip_lin    = {ipsel_q, 4'h0} + {4'h0, ipoff_q};
    assign op_lin    = {opsel_q, 4'h0} + {4'h0, opoff_q};
    assign vac_slot  = 3'(top + op_reg);

    always_comb
    begin
        stat_rd          = stat_q;
        stat_rd[ST_ES]   = pending;
        stat_rd[ST_BUSY] = op_busy_q;
    end

    // Image words; real and virtual-8086 modes fold the pointers into 20-bit addresses
    always_comb
    begin
        env_wd = '0;
        if (!(wide_q && k_q[0]))
        begin
            unique case (env_idx)
                RA_CTRL:  env_wd = ctrl_q;
                RA_STAT:  env_wd = stat_rd;
                RA_TAG:   env_wd = tscan_q;
                RA_IPOFF: env_wd = real_q ? ip_lin[15:0] : ipoff_q;
                RA_IPSEL: env_wd = real_q ? {ip_lin[19:16], 12'h000} : ipsel_q;
                RA_OPOFF: env_wd = real_q ? op_lin[15:0] : opoff_q;
                RA_OPSEL: env_wd = real_q ? {op_lin[19:16], 12'h000} : opsel_q;
                default:  env_wd = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= S_IDLE;
        end
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    if (refuse)
                    begin
                        state_q <= S_DONE;
                    end
                    else if (go)
                    begin
                        unique case (op_code)
                            OP_STENV:   state_q <= S_DRAIN;
                            OP_LDENV:   state_q <= S_LREQ;
                            OP_RESTORE: state_q <= S_LREQ;
                            default:    state_q <= S_DONE;
                        endcase
                    end
                end
                S_DRAIN:
                begin
                    if (!numeric_busy)
                    begin
                        state_q <= S_SCAN;
                    end
                end
                S_SCAN:
                begin
                    if (scan_last)
                    begin
                        state_q <= S_STORE;
                    end
                end
                S_STORE:
                begin
                    if (k_last)
                    begin
                        state_q <= S_DONE;
                    end
                end
                S_LREQ:  state_q <= S_LWAIT;
                S_LWAIT:
                begin
                    if (xfer_rvalid)
                    begin
                        state_q <= k_last ? S_DONE : S_LREQ;
                    end
                end
                S_DONE:  state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            opc_q  <= OP_IDLE;
            wide_q <= 1'b0;
            real_q <= 1'b0;
            k_q    <= '0;
        end
        else
        begin
            if (accept)
            begin
                opc_q  <= op_code;
                wide_q <= opsize32;
                real_q <= !prot_mode || v86_mode;
                k_q    <= '0;
            end
            else if ((state_q == S_STORE) || ld_we)
            begin
                k_q <= 6'(k_q + 6'h01);
            end
        end
    end

    // Busy covers the whole transfer so the host cannot start the next op early
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            op_busy_q <= 1'b0;
            op_done_q <= 1'b0;
            op_err_q  <= 1'b0;
        end
        else
        begin
            op_done_q <= (state_q == S_DONE);
            if (accept)
            begin
                op_busy_q <= 1'b1;
                op_err_q  <= refuse;
            end
            else if (state_q == S_DONE)
            begin
                op_busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            xfer_rd_q    <= 1'b0;
            xfer_wr_q    <= 1'b0;
            xfer_addr_q  <= '0;
            xfer_wdata_q <= '0;
        end
        else
        begin
            xfer_rd_q <= (state_q == S_LREQ);
            xfer_wr_q <= (state_q == S_STORE);
            if ((state_q == S_LREQ) || (state_q == S_STORE))
            begin
                xfer_addr_q  <= k_q;
                xfer_wdata_q <= env_wd;
            end
        end
    end

    // Tag scan: one slot word per cycle, classified once its exponent word arrives
    always_comb
    begin
        cls = TAG_VALID;
        if (mem_rdata[14:0] == EXP_MIN)
        begin
            cls = (mnz_q || int_q) ? TAG_SPEC : TAG_ZERO;
        end
        else if ((mem_rdata[14:0] == EXP_MAX) || !int_q)
        begin
            cls = TAG_SPEC;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ri_q    <= '0;
            wj_q    <= '0;
            pv_q    <= 1'b0;
            pri_q   <= '0;
            pwj_q   <= '0;
            mnz_q   <= 1'b0;
            int_q   <= 1'b0;
            tscan_q <= TAG_RST;
        end
        else
        begin
            pv_q  <= (state_q == S_SCAN);
            pri_q <= ri_q;
            pwj_q <= wj_q;
            if (state_q == S_DRAIN)
            begin
                ri_q <= '0;
                wj_q <= '0;
            end
            else if (state_q == S_SCAN)
            begin
                wj_q <= (wj_q == WORD_LAST) ? 3'h0 : 3'(wj_q + 3'h1);
                ri_q <= (wj_q == WORD_LAST) ? 3'(ri_q + 3'h1) : ri_q;
            end
            if (pv_q && (pwj_q != WORD_LAST))
            begin
                mnz_q <= ((pwj_q == 3'h0) ? 1'b0 : mnz_q) | (|mem_rdata);
                if (pwj_q == INT_WORD)
                begin
                    mnz_q <= mnz_q | (|mem_rdata[14:0]);
                    int_q <= mem_rdata[15];
                end
            end
            else if (pv_q)
            begin
                tscan_q[2*pri_q +: 2] <= (tag_q[2*pri_q +: 2] == TAG_EMPTY)
                                         ? TAG_EMPTY : cls;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q   <= CTRL_RST;
            cw_upd_q <= 1'b0;
        end
        else
        begin
            cw_upd_q <= (reg_wr && (reg_addr == RA_CTRL)) || (ld_fld && (env_idx == RA_CTRL));
            if (reg_wr && (reg_addr == RA_CTRL))
            begin
                ctrl_q <= reg_wdata;
            end
            else if (ld_fld && (env_idx == RA_CTRL))
            begin
                ctrl_q <= xfer_rdata;
            end
            else if ((state_q == S_STORE) && k_last)
            begin
                ctrl_q[EXC_W-1:0] <= MASK_ALL;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_q <= STAT_RST;
        end
        else
        begin
            if (reg_wr && (reg_addr == RA_STAT))
            begin
                stat_q <= reg_wdata;
            end
            else if (ld_fld && (env_idx == RA_STAT))
            begin
                stat_q <= xfer_rdata;
            end
            else if (go && (op_code == OP_ADV))
            begin
                stat_q[ST_TOP_LO +: ST_TOP_W] <= 3'(top + 3'h1);
            end
            else if (go && (op_code == OP_RET))
            begin
                stat_q[ST_TOP_LO +: ST_TOP_W] <= 3'(top - 3'h1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tag_q <= TAG_RST;
        end
        else
        begin
            if (reg_wr && (reg_addr == RA_TAG))
            begin
                tag_q <= reg_wdata;
            end
            else if (ld_fld && (env_idx == RA_TAG))
            begin
                tag_q <= xfer_rdata;
            end
            else if (go && (op_code == OP_VACATE))
            begin
                tag_q[2*vac_slot +: 2] <= TAG_EMPTY;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ipoff_q <= '0;
            ipsel_q <= '0;
            opoff_q <= '0;
            opsel_q <= '0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                RA_IPOFF: ipoff_q <= reg_wdata;
                RA_IPSEL: ipsel_q <= reg_wdata;
                RA_OPOFF: opoff_q <= reg_wdata;
                RA_OPSEL: opsel_q <= reg_wdata;
                default:  ;
            endcase
        end
        else if (ld_fld)
        begin
            unique case (env_idx)
                RA_IPOFF: ipoff_q <= xfer_rdata;
                RA_IPSEL: ipsel_q <= real_q ? {xfer_rdata[15:12], 12'h000} : xfer_rdata;
                RA_OPOFF: opoff_q <= xfer_rdata;
                RA_OPSEL: opsel_q <= real_q ? {xfer_rdata[15:12], 12'h000} : xfer_rdata;
                default:  ;
            endcase
        end
    end

    // Raised by a sync, a checked opcode or a control-word update, including the one made by a reload
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            numeric_fault_line_q <= 1'b0;
        end
        else if (pending && (host_sync || (accept && op_checked) || cw_upd_q))
        begin
            numeric_fault_line_q <= 1'b1;
        end
        else if (!pending)
        begin
            numeric_fault_line_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata_q <= '0;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                RA_CTRL:  reg_rdata_q <= ctrl_q;
                RA_STAT:  reg_rdata_q <= stat_rd;
                RA_TAG:   reg_rdata_q <= tag_q;
                RA_IPOFF: reg_rdata_q <= ipoff_q;
                RA_IPSEL: reg_rdata_q <= ipsel_q;
                RA_OPOFF: reg_rdata_q <= opoff_q;
                RA_OPSEL: reg_rdata_q <= opsel_q;
                default:  reg_rdata_q <= '0;
            endcase
        end
    end

    npxc_slot_mem #(.AW(6), .DW(16), .DEPTH(40)) u_slots (
        .clk       (clk),
        .rstn      (rstn),
        .wr_en     (mem_we),
        .wr_addr   (mem_waddr),
        .wr_data   (xfer_rdata),
        .rd_addr   (mem_raddr),
        .rd_data_q (mem_rdata)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    adv_wrap_a:
        assert property (go && op_code == OP_ADV && !reg_wr |=> top == 3'($past(top) + 3'h1))
        else $error("head advance wrong");
    ret_wrap_a:
        assert property (go && op_code == OP_RET && !reg_wr |=> top == 3'($past(top) - 3'h1))
        else $error("head retreat wrong");
    vacate_tag_a:
        assert property (go && op_code == OP_VACATE && !reg_wr
                         |=> tag_q[2*$past(vac_slot) +: 2] == TAG_EMPTY)
        else $error("slot not vacated");
    mask_all_a:
        assert property (state_q == S_STORE && k_last && !reg_wr
                         |=> ctrl_q[EXC_W-1:0] == MASK_ALL ##1 op_done_q)
        else $error("masks not set after store");
    drain_hold_a:
        assert property (state_q == S_DRAIN && numeric_busy |=> state_q == S_DRAIN && !xfer_wr_q)
        else $error("store ran during activity");
    refuse_chk_a:
        assert property (refuse |=> ##1 op_done_q && op_err_q && numeric_fault_line_q)
        else $error("checked op not refused");
    idle_keep_a:
        assert property (go && op_code == OP_IDLE && !reg_wr
                         |=> $stable(ctrl_q) && $stable(stat_q) && $stable(tag_q) ##1 op_done_q)
        else $error("idle op changed state");
    load_busy_a:
        assert property (state_q == S_LWAIT |-> op_busy_q && !op_done_q)
        else $error("done during restore wait");
    sync_fault_a:
        assert property (host_sync && pending |=> numeric_fault_line_q)
        else $error("fault not raised at sync");

    restore_c: cover property (go && op_code == OP_RESTORE ##[1:400] op_done_q);
    stenv_c:   cover property (go && op_code == OP_STENV ##[1:400] op_done_q);
    unmask_c:  cover property (cw_upd_q && pending ##1 numeric_fault_line_q);

endmodule // npxc_control_unit

/* File: src/npxc_pkg.sv */
// Constants and types of the numeric coprocessor control-instruction unit.
// Assumes one core clock and a host that moves memory operands word by word.
// Function
// - Full-state restore reloads environment and all register data from host image.
// - Restore holds the unit busy until every transfer of it has finished.
// - Restored unmasked exception raises a fault at the next sync or checked opcode.
// - Environment store writes control, status, tag words and both exception pointers.
// - After an environment store every exception mask bit is set.
// - Checked environment store tests for pending exceptions; unchecked one does not.
// - Unchecked environment store waits until numeric activity has drained.
// - Image layout follows real or protected mode and 16 or 32 bit size.
// - Stored tag of each non-empty register is derived from its actual contents.
// - Environment reload finishes all its transfers before the next instruction.
// - Reloaded unmasked exception faults at the next sync or checked opcode.
// - Head advance adds one modulo eight, touching no tags, data or memory.
// - Head retreat subtracts one modulo eight, touching no tags, data or memory.
// - Slot vacate marks the named register empty and keeps its data.
// - Idle op changes no architectural state.
// - Unchecked variants ignore pending exceptions; checked variants test them first.
// - Unmasking an exception whose flag is set raises the fault line.
package npxc_pkg;

    localparam logic [3:0]  OP_IDLE    = 4'h0;
    localparam logic [3:0]  OP_ADV     = 4'h1;
    localparam logic [3:0]  OP_RET     = 4'h2;
    localparam logic [3:0]  OP_VACATE  = 4'h3;
    localparam logic [3:0]  OP_STENV   = 4'h4;
    localparam logic [3:0]  OP_LDENV   = 4'h5;
    localparam logic [3:0]  OP_RESTORE = 4'h6;

    // Register indexes, also the word order inside the environment image
    localparam logic [2:0]  RA_CTRL    = 3'h0;
    localparam logic [2:0]  RA_STAT    = 3'h1;
    localparam logic [2:0]  RA_TAG     = 3'h2;
    localparam logic [2:0]  RA_IPOFF   = 3'h3;
    localparam logic [2:0]  RA_IPSEL   = 3'h4;
    localparam logic [2:0]  RA_OPOFF   = 3'h5;
    localparam logic [2:0]  RA_OPSEL   = 3'h6;

    localparam int          EXC_W      = 6;
    localparam int          ST_ES      = 7;
    localparam int          ST_TOP_LO  = 11;
    localparam int          ST_TOP_W   = 3;
    localparam int          ST_BUSY    = 15;
    localparam int          SEG_SHIFT  = 4;

    localparam logic [15:0] CTRL_RST   = 16'h037F;
    localparam logic [15:0] STAT_RST   = 16'h0000;
    localparam logic [15:0] TAG_RST    = 16'hFFFF;
    localparam logic [5:0]  MASK_ALL   = 6'h3F;

    localparam logic [1:0]  TAG_VALID  = 2'h0;
    localparam logic [1:0]  TAG_ZERO   = 2'h1;
    localparam logic [1:0]  TAG_SPEC   = 2'h2;
    localparam logic [1:0]  TAG_EMPTY  = 2'h3;
    localparam logic [14:0] EXP_MAX    = 15'h7FFF;
    localparam logic [14:0] EXP_MIN    = 15'h0000;

    localparam logic [5:0]  ENV_WORDS  = 6'h07;
    localparam logic [5:0]  DATA_WORDS = 6'h28;
    localparam logic [2:0]  WORD_LAST  = 3'h4;
    localparam logic [2:0]  INT_WORD   = 3'h3;
    localparam logic [2:0]  SLOT_LAST  = 3'h7;
    localparam logic [5:0]  SLOT_WORDS = 6'h05;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_DRAIN = 3'h1,
        S_SCAN  = 3'h3,
        S_STORE = 3'h2,
        S_DONE  = 3'h6,
        S_LREQ  = 3'h4,
        S_LWAIT = 3'h5
    } npxc_state_type;

endpackage

/* File: src/npxc_slot_mem.sv */
// Register-stack data store, one 16-bit word per entry, five words per slot.
// Assumes one writer and one reader; read data appear one cycle after the address.
`timescale 1ns/1ps
module npxc_slot_mem #(
    parameter int AW    = 6,
    parameter int DW    = 16,
    parameter int DEPTH = 40
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data_q
);

    logic [DW-1:0] mem_q [DEPTH];

    // No reset on the array: contents are undefined until loaded
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data_q <= '0;
        end
        else
        begin
            rd_data_q <= mem_q[rd_addr];
        end
    end

endmodule // npxc_slot_mem
